// *** nand_host_pkg.sv ***
package nand_host_pkg;

	// Clock rate and conversion of printed times to clock cycles
	localparam int CLK_MHZ = 50;
	localparam int SYNC_STAGES = 2;

	// Least time in ns to whole cycles, rounded up, never below one
	function automatic int ns_min_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : ns_min_cyc

	// Bus timing in ns and power-up time in us, as printed for the device pins
	localparam int T_WP_NS = 25;
	localparam int T_WH_NS = 15;
	localparam int T_RP_NS = 25;
	localparam int T_REH_NS = 15;
	localparam int T_REA_NS = 30;
	localparam int T_WB_NS = 100;
	localparam int T_WHR_NS = 60;
	localparam int T_PWRUP_US = 10;

	localparam logic [15:0] WP_CYC = 16'(ns_min_cyc(T_WP_NS));
	localparam logic [15:0] WR_CYC = 16'(ns_min_cyc(T_WP_NS) + ns_min_cyc(T_WH_NS));
	// Read data crosses the pin register and two synchroniser stages before sampling
	localparam logic [15:0] RE_LOW_CYC = 16'(ns_min_cyc(T_REA_NS) + SYNC_STAGES + 1);
	localparam logic [15:0] RD_CYC = 16'(ns_min_cyc(T_REA_NS) + SYNC_STAGES + 1
		+ ns_min_cyc(T_REH_NS));
	localparam logic [15:0] WB_CYC = 16'(ns_min_cyc(T_WB_NS));
	localparam logic [15:0] WHR_CYC = 16'(ns_min_cyc(T_WHR_NS));
	localparam logic [15:0] PWRUP_CYC = 16'(ns_min_cyc(T_PWRUP_US * 1000));

	// Command codes
	localparam logic [7:0] CMD_READ_MAIN = 8'h00;
	localparam logic [7:0] CMD_COPY_READ = 8'h03;
	localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_PROG_DUMMY = 8'h11;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_MP_STATUS = 8'h71;
	localparam logic [7:0] CMD_COPY_INPUT = 8'h8A;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_RESET = 8'hFF;

	// Device status register: reset value and field positions
	localparam logic [7:0] STATUS_RESET = 8'hC0;
	localparam int ST_FAIL_BIT = 0;
	localparam int ST_PLANE_LSB = 1;
	localparam int ST_RDY_BIT = 6;
	localparam int ST_WP_BIT = 7;

	// Plane select bits A14/A15 inside the user address word
	localparam int PAGE_PLANE_LSB = 13;
	localparam int BLOCK_PLANE_LSB = 5;
	localparam logic [2:0] PAGE_ADDR_CYCLES = 3'h4;
	localparam logic [2:0] BLOCK_ADDR_CYCLES = 3'h3;
	localparam logic [2:0] ID_READS = 3'h4;
	localparam logic [2:0] ID_IGNORED_INDEX = 3'h2;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 8;

	typedef enum logic [3:0] {
		OP_RESET = 4'h0,
		OP_STATUS = 4'h1,
		OP_MP_STATUS = 4'h2,
		OP_READ_ID = 4'h3,
		OP_ERASE_QUEUE = 4'h4,
		OP_ERASE_START = 4'h5,
		OP_COPY_SOURCE = 4'h6,
		OP_COPY_DEST = 4'h7
	} nand_op_e;

	typedef struct packed {
		logic wp_clear;
		logic ready;
		logic reserved;
		logic [3:0] plane_fail;
		logic total_fail;
	} nand_status_s;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic output_strobe_n;
	} nand_ctrl_s;

endpackage : nand_host_pkg

// *** byte_fifo.sv ***
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full and empty come straight from the occupancy count
	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_ptr_q];

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage needs no reset; unwritten words are never shown as valid
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

endmodule : byte_fifo

// *** nand_host.sv ***
// Function
// [RULE1] Queue up to four erase-setup commands, each with three address cycles.
// [RULE2] Refuse a second erase block in a plane already queued.
// [RULE3] Erase-confirm starts erase; wait for ready on the busy pin.
// [RULE4] Per-plane erase result is read back in extended status bits 1-4.
// [RULE5] Copy source read moves the page inside; no data is burst out.
// [RULE6] Wait ready after source read, then copy-input, address, confirm.
// [RULE7] Destination plane bits A14/A15 must match a queued source plane.
// [RULE8] Copied pages are never partially programmed by this controller.
// [RULE9] First source read uses 00h, further ones 03h, four at most.
// [RULE10] Dummy program between destination planes, true confirm after the last.
// [RULE11] No pointer commands are issued during multi-plane copy-back.
// [RULE12] Status byte is sampled on a read strobe after the status command.
// [RULE13] Status mode persists; a read command precedes sequential reads.
// [RULE14] Pass/fail bits are taken only once status shows ready.
// [RULE15] Status bit 0 gives overall pass or fail.
// [RULE16] Bits 1-4 give per-plane results under multi-plane status only.
// [RULE17] Status bit 6 polled as busy 0, ready 1.
// [RULE18] Read ID: 90h, address 00h, four reads; reserved third byte dropped.
// [RULE19] Reset command aborts operations and clears queued state.
// [RULE20] Device loads status C0h on reset when write-protect is high.
// [RULE21] Reset busy time is waited out on the busy pin.
// [RULE22] Busy pin low after accepted operations; wait until it returns high.
// [RULE23] Hold off all commands for the power-up recovery time.
// [RULE24] Nothing but waiting happens while the device programs.
// [RULE25] Dummy program ends one plane's loading without programming.
// [RULE26] Status bit 5 is reserved and ignored.
`timescale 1ns/1ps
module nand_host
	import nand_host_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic req_valid,
	output logic req_ready,
	input wire nand_op_e req_op,
	input wire logic [31:0] req_addr,
	output logic req_error,
	output logic op_busy,
	output nand_status_s status,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	output nand_ctrl_s ctrl,
	output logic wp_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic ready_busy
);

	typedef enum logic [3:0] {
		ST_POWERUP = 4'h0,
		ST_IDLE = 4'h1,
		ST_CMD1 = 4'h2,
		ST_ADDR = 4'h3,
		ST_CMD2 = 4'h4,
		ST_WB = 4'h5,
		ST_RB = 4'h6,
		ST_WHR = 4'h7,
		ST_READ = 4'h8
	} state_e;

	// One-hot plane mask from the user address, by address layout of the operation
	function automatic logic [3:0] plane_bit(input nand_op_e op, input logic [31:0] a);
		logic [1:0] p;
		p = (op == OP_ERASE_QUEUE) ? a[BLOCK_PLANE_LSB +: 2] : a[PAGE_PLANE_LSB +: 2];
		return 4'h1 << p;
	endfunction : plane_bit

	state_e state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [7:0] cmd1_q, cmd1_d;
	logic [7:0] cmd2_q, cmd2_d;
	logic has_cmd2_q, has_cmd2_d;
	logic waits_q, waits_d;
	logic [2:0] naddr_q, naddr_d;
	logic [2:0] nreads_q, nreads_d;
	logic [2:0] rd_idx_q, rd_idx_d;
	logic [31:0] addr_q, addr_d;
	nand_op_e op_q, op_d;
	logic [3:0] erase_mask_q, erase_mask_d;
	logic [3:0] src_mask_q, src_mask_d;
	logic [3:0] dst_mask_q, dst_mask_d;
	nand_status_s status_q, status_d;
	logic error_q, error_d;
	logic wp_n_q, wp_n_d;
	nand_ctrl_s ctrl_q, ctrl_d;
	logic [7:0] io_out_q, io_out_d;
	logic io_oe_q, io_oe_d;
	logic [7:0] io_s1_q, io_s2_q;
	logic rb_s1_q, rb_s2_q;

	// Request decode
	wire accept = req_valid && req_ready;
	wire [3:0] pbit = plane_bit(req_op, req_addr);
	wire [2:0] erase_count = 3'(erase_mask_q[0]) + 3'(erase_mask_q[1])
		+ 3'(erase_mask_q[2]) + 3'(erase_mask_q[3]);
	wire erase_bad = (erase_mask_q & pbit) != 4'h0; // [RULE2]
	wire src_bad = (src_mask_q & pbit) != 4'h0 || dst_mask_q != 4'h0;
	wire dst_bad = (src_mask_q & pbit) == 4'h0 || (dst_mask_q & pbit) != 4'h0; // [RULE7]
	wire dst_last = (dst_mask_q | pbit) == src_mask_q;
	wire start_bad = erase_mask_q == 4'h0 || erase_count > 3'h4;

	// Strobe engine decode
	wire wr_end = cnt_q == WR_CYC - 16'h1;
	wire rd_end = cnt_q == RD_CYC - 16'h1;
	wire rd_sample = cnt_q == RE_LOW_CYC - 16'h1;
	wire is_status = op_q == OP_STATUS || op_q == OP_MP_STATUS;
	wire status_busy = is_status && !io_s2_q[ST_RDY_BIT]; // [RULE17]
	wire drop_byte = op_q == OP_READ_ID && rd_idx_q == ID_IGNORED_INDEX; // [RULE18]
	wire fifo_ready;
	wire push = state_q == ST_READ && rd_sample && !status_busy && !drop_byte;

	assign req_ready = state_q == ST_IDLE;
	assign op_busy = state_q != ST_IDLE;
	assign req_error = error_q;
	assign status = status_q;
	assign ctrl = ctrl_q;
	assign wp_n = wp_n_q;
	assign io_out = io_out_q;
	assign io_oe = io_oe_q;

	// Read bytes wait here; a full buffer holds off the next read strobe
	byte_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(io_s2_q),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// Sequencer: one operation at a time, so a busy device sees no other command
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + 16'h1;
		cmd1_d = cmd1_q;
		cmd2_d = cmd2_q;
		has_cmd2_d = has_cmd2_q;
		waits_d = waits_q;
		naddr_d = naddr_q;
		nreads_d = nreads_q;
		rd_idx_d = rd_idx_q;
		addr_d = addr_q;
		op_d = op_q;
		erase_mask_d = erase_mask_q;
		src_mask_d = src_mask_q;
		dst_mask_d = dst_mask_q;
		status_d = status_q;
		error_d = 1'b0;
		wp_n_d = wp_n_q;
		case (state_q)
			ST_POWERUP: begin
				if (cnt_q == PWRUP_CYC - 16'h1) begin // [RULE23]
					wp_n_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				cnt_d = 16'h0;
				if (accept) begin
					op_d = req_op;
					addr_d = req_addr;
					has_cmd2_d = 1'b0;
					waits_d = 1'b0;
					naddr_d = 3'h0;
					nreads_d = 3'h0;
					rd_idx_d = 3'h0;
					state_d = ST_CMD1;
					case (req_op)
						OP_RESET: begin
							cmd1_d = CMD_RESET;
							waits_d = 1'b1; // [RULE21]
							erase_mask_d = 4'h0; // [RULE19]
							src_mask_d = 4'h0;
							dst_mask_d = 4'h0;
							status_d = nand_status_s'(STATUS_RESET); // [RULE20]
						end
						OP_STATUS: begin
							cmd1_d = CMD_STATUS;
							nreads_d = 3'h1; // [RULE12]
						end
						OP_MP_STATUS: begin
							cmd1_d = CMD_MP_STATUS; // [RULE14]
							nreads_d = 3'h1;
						end
						OP_READ_ID: begin
							cmd1_d = CMD_READ_ID;
							addr_d = 32'h0;
							naddr_d = 3'h1;
							nreads_d = ID_READS; // [RULE18]
						end
						OP_ERASE_QUEUE: begin
							cmd1_d = CMD_ERASE_SETUP;
							naddr_d = BLOCK_ADDR_CYCLES; // [RULE1]
							if (erase_bad) begin
								error_d = 1'b1;
								state_d = ST_IDLE;
							end else begin
								erase_mask_d = erase_mask_q | pbit;
							end
						end
						OP_ERASE_START: begin
							cmd1_d = CMD_ERASE_CONFIRM; // [RULE3]
							waits_d = 1'b1;
							erase_mask_d = 4'h0;
							if (start_bad) begin
								error_d = 1'b1;
								erase_mask_d = erase_mask_q;
								state_d = ST_IDLE;
							end
						end
						OP_COPY_SOURCE: begin
							// First source page uses the normal read, the rest the copy read
							cmd1_d = (src_mask_q == 4'h0) ? CMD_READ_MAIN : CMD_COPY_READ; // [RULE9]
							naddr_d = PAGE_ADDR_CYCLES;
							waits_d = 1'b1; // [RULE5]
							if (src_bad) begin
								error_d = 1'b1;
								state_d = ST_IDLE;
							end else begin
								src_mask_d = src_mask_q | pbit;
							end
						end
						OP_COPY_DEST: begin
							cmd1_d = CMD_COPY_INPUT; // [RULE6]
							naddr_d = PAGE_ADDR_CYCLES;
							has_cmd2_d = 1'b1;
							waits_d = 1'b1;
							// Dummy confirm between planes, true confirm once all sources land
							cmd2_d = dst_last ? CMD_PROG_CONFIRM : CMD_PROG_DUMMY; // [RULE10] [RULE25]
							if (dst_bad) begin
								error_d = 1'b1;
								state_d = ST_IDLE;
							end else if (dst_last) begin
								src_mask_d = 4'h0;
								dst_mask_d = 4'h0;
							end else begin
								dst_mask_d = dst_mask_q | pbit;
							end
						end
						default: begin
							error_d = 1'b1; // [RULE8] [RULE11]
							state_d = ST_IDLE;
						end
					endcase
				end
			end
			ST_CMD1, ST_ADDR, ST_CMD2: begin
				if (wr_end) begin
					cnt_d = 16'h0;
					if (state_q == ST_ADDR) begin
						addr_d = addr_q >> 8;
						naddr_d = naddr_q - 3'h1;
					end
					if (state_q != ST_CMD2 && (naddr_d != 3'h0)) begin
						state_d = ST_ADDR;
					end else if (state_q != ST_CMD2 && has_cmd2_q) begin
						state_d = ST_CMD2;
					end else if (waits_q) begin
						state_d = ST_WB; // [RULE22]
					end else if (nreads_q != 3'h0) begin
						state_d = ST_WHR;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_WB: begin
				if (cnt_q == WB_CYC - 16'h1) begin
					state_d = ST_RB;
				end
			end
			ST_RB: begin
				// Ready pin high means the internal operation is over
				if (rb_s2_q) begin // [RULE22] [RULE24]
					state_d = ST_IDLE;
				end
			end
			ST_WHR: begin
				if (cnt_q == WHR_CYC - 16'h1) begin
					cnt_d = 16'h0;
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				// A read strobe starts only when the buffer can take its byte
				if (cnt_q == 16'h0 && !fifo_ready) begin
					cnt_d = 16'h0;
				end
				if (rd_sample && is_status && !status_busy) begin
					status_d = nand_status_s'(io_s2_q); // [RULE4] [RULE14] [RULE15]
					status_d.reserved = 1'b0; // [RULE26]
					if (op_q == OP_STATUS) begin
						status_d.plane_fail = 4'h0; // [RULE16]
					end
				end
				if (rd_end) begin
					cnt_d = 16'h0;
					// Busy status repeats the read; the byte updates on each strobe
					if (!status_busy) begin // [RULE17]
						rd_idx_d = rd_idx_q + 3'h1;
						nreads_d = nreads_q - 3'h1;
						if (nreads_q == 3'h1) begin
							state_d = ST_IDLE; // [RULE13]
						end
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Pin drive follows the state one cycle later, keeping setup and hold alike
	always_comb begin
		ctrl_d = '{ce_n: 1'b0, cle: 1'b0, ale: 1'b0, we_n: 1'b1, output_strobe_n: 1'b1};
		io_out_d = 8'h00;
		io_oe_d = 1'b0;
		case (state_q)
			ST_POWERUP, ST_IDLE: begin
				ctrl_d.ce_n = 1'b1;
			end
			ST_CMD1, ST_CMD2: begin
				ctrl_d.cle = 1'b1;
				ctrl_d.we_n = cnt_q >= WP_CYC;
				io_out_d = (state_q == ST_CMD1) ? cmd1_q : cmd2_q;
				io_oe_d = 1'b1;
			end
			ST_ADDR: begin
				ctrl_d.ale = 1'b1;
				ctrl_d.we_n = cnt_q >= WP_CYC;
				io_out_d = addr_q[7:0];
				io_oe_d = 1'b1;
			end
			ST_READ: begin
				ctrl_d.output_strobe_n = !(cnt_q < RE_LOW_CYC && (cnt_q != 16'h0 || fifo_ready));
			end
			default: begin
			end
		endcase
	end

	// Control registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_q <= ST_POWERUP;
			cnt_q <= 16'h0;
			cmd1_q <= 8'h00;
			cmd2_q <= 8'h00;
			has_cmd2_q <= 1'b0;
			waits_q <= 1'b0;
			naddr_q <= 3'h0;
			nreads_q <= 3'h0;
			rd_idx_q <= 3'h0;
			addr_q <= 32'h0;
			op_q <= OP_RESET;
			erase_mask_q <= 4'h0;
			src_mask_q <= 4'h0;
			dst_mask_q <= 4'h0;
			status_q <= nand_status_s'(STATUS_RESET);
			error_q <= 1'b0;
			wp_n_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cmd1_q <= cmd1_d;
			cmd2_q <= cmd2_d;
			has_cmd2_q <= has_cmd2_d;
			waits_q <= waits_d;
			naddr_q <= naddr_d;
			nreads_q <= nreads_d;
			rd_idx_q <= rd_idx_d;
			addr_q <= addr_d;
			op_q <= op_d;
			erase_mask_q <= erase_mask_d;
			src_mask_q <= src_mask_d;
			dst_mask_q <= dst_mask_d;
			status_q <= status_d;
			error_q <= error_d;
			wp_n_q <= wp_n_d;
		end
	end

	// Pin registers and two-stage synchronisers on the pin inputs
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ctrl_q <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, output_strobe_n: 1'b1};
			io_out_q <= 8'h00;
			io_oe_q <= 1'b0;
			io_s1_q <= 8'h00;
			io_s2_q <= 8'h00;
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			io_out_q <= io_out_d;
			io_oe_q <= io_oe_d;
			io_s1_q <= io_in;
			io_s2_q <= io_s1_q;
			rb_s1_q <= ready_busy;
			rb_s2_q <= rb_s1_q;
		end
	end

endmodule : nand_host

// *** nand_host_properties.sv ***
`timescale 1ns/1ps
module nand_host_properties
	import nand_host_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire nand_op_e req_op,
	input wire logic [31:0] req_addr,
	input wire logic req_error,
	input wire logic op_busy,
	input wire nand_status_s status,
	input wire logic rd_valid,
	input wire logic rd_ready,
	input wire logic [7:0] rd_data,
	input wire nand_ctrl_s ctrl,
	input wire logic wp_n,
	input wire logic [7:0] io_in,
	input wire logic [7:0] io_out,
	input wire logic io_oe,
	input wire logic ready_busy
);
	logic [15:0] up_q;

	// Cycles since reset release; saturates so a long run never wraps into the window
	always_ff @(posedge clock) begin
		if (!resetn)
			up_q <= 16'h0000;
		else if (up_q != 16'hFFFF)
			up_q <= up_q + 16'h0001;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// One bus write: strobe low two cycles, then high
	sequence write_pulse;
		!ctrl.we_n [*2] ##1 ctrl.we_n;
	endsequence
	// Device busy long enough for the synchroniser to have seen it
	sequence busy_hold;
		!ready_busy [*4];
	endsequence

	pwrup_hold_a: assert property (up_q < PWRUP_CYC - 16'h0001 |-> !req_ready && !wp_n)
		else $error("request taken during power-up wait");
	wp_ready_a: assert property ($rose(wp_n) |-> ##[0:2] req_ready)
		else $error("idle not reached after power-up");
	accept_busy_a: assert property (req_valid && req_ready |=> op_busy != req_error)
		else $error("accepted request neither busy nor refused");
	ready_idle_a: assert property (req_ready |-> !op_busy)
		else $error("ready while busy");
	err_pulse_a: assert property (req_error |=> !req_error)
		else $error("refusal flag longer than one cycle");
	write_len_a: assert property ($fell(ctrl.we_n) |-> write_pulse and (io_oe && !ctrl.ce_n) [*3])
		else $error("malformed write cycle");
	read_dir_a: assert property (!ctrl.output_strobe_n |-> !io_oe && !ctrl.ce_n && ctrl.we_n)
		else $error("host drives bus during read");
	quiet_busy_a: assert property (busy_hold |-> ctrl.we_n && ctrl.output_strobe_n)
		else $error("bus activity while device busy");
	resv_zero_a: assert property (!$stable(status) |-> !status.reserved && status.ready)
		else $error("status taken before ready or reserved bit set");
	fail_sum_a: assert property (|status.plane_fail |-> status.total_fail)
		else $error("plane failure without total failure");
	reset_status_a: assert property (req_valid && req_ready && req_op == OP_RESET
		|-> ##[1:400] status == STATUS_RESET)
		else $error("reset did not restore status");
endmodule : nand_host_properties

bind nand_host nand_host_properties u_props (.clock(clock), .resetn(resetn),
	.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
	.req_error(req_error), .op_busy(op_busy), .status(status), .rd_valid(rd_valid),
	.rd_ready(rd_ready), .rd_data(rd_data), .ctrl(ctrl), .wp_n(wp_n), .io_in(io_in),
	.io_out(io_out), .io_oe(io_oe), .ready_busy(ready_busy));

// *** nand_dev_model.sv ***
`timescale 1ns/1ps
module nand_dev_model
	import nand_host_pkg::*;
#(
	parameter int BUSY_CYC = 40,
	parameter int LOAD_CYC = 4,
	parameter logic [7:0] MAKER_ID = 8'h11, // Arbitrary value
	parameter logic [7:0] PART_ID = 8'h22, // Arbitrary value
	parameter logic [7:0] RSVD_ID = 8'h33 // Arbitrary value
) (
	input wire logic clock,
	input wire nand_ctrl_s ctrl,
	input wire logic [7:0] io_bus,
	input wire logic wp_n,
	input wire logic [3:0] fail_planes,
	output logic [7:0] dev_data,
	output logic rb_low
);
	logic [7:0] cmd_log[$];
	logic [7:0] last_q = 8'h00;
	logic [7:0] cmd_q = 8'h00;
	logic [3:0] fail_q = 4'h0;
	logic we_q = 1'b1;
	logic re_q = 1'b1;
	logic wp_q = 1'b1;
	logic rst_q = 1'b0;
	int busy_q = 0;
	int mode_q = 0;
	int id_q = 0;
	int addr_q = 0;
	logic [7:0] rd_byte;
	logic drive;
	logic we_rise;

	// Reserved bit is a fixed 1 so the host must mask it; ready tracks busy live
	always_comb begin
		if (mode_q == 2)
			rd_byte = (id_q == 0) ? MAKER_ID : (id_q == 1) ? PART_ID : (id_q == 2) ? RSVD_ID : 8'hC0;
		else
			rd_byte = {wp_q, busy_q == 0, 1'b1, fail_q, |fail_q};
	end

	// A released bus shows the inverse of the last byte, never a stale copy
	assign drive = !ctrl.ce_n && !ctrl.output_strobe_n && mode_q != 0;
	assign dev_data = drive ? rd_byte : ~last_q;
	assign rb_low = busy_q != 0;
	assign we_rise = !we_q && ctrl.we_n && !ctrl.ce_n;

	// Commands and addresses latch on the write strobe rising edge
	always @(posedge clock) begin
		we_q <= ctrl.we_n;
		re_q <= ctrl.output_strobe_n;
		if (drive)
			last_q <= rd_byte;
		if (busy_q != 0)
			busy_q <= busy_q - 1;
		if (busy_q == 1)
			rst_q <= 1'b0;
		if (!re_q && ctrl.output_strobe_n && mode_q == 2)
			id_q <= id_q + 1;
		if (we_rise && ctrl.cle) begin
			cmd_log.push_back(io_bus);
			cmd_q <= io_bus;
			addr_q <= 0;
			id_q <= 0;
			mode_q <= (io_bus == CMD_STATUS || io_bus == CMD_MP_STATUS) ? 1 : (io_bus == CMD_READ_ID) ? 2 : 0;
			if (io_bus == CMD_RESET && !rst_q) begin
				busy_q <= BUSY_CYC;
				rst_q <= 1'b1;
				wp_q <= wp_n;
				fail_q <= 4'h0;
			end else if (busy_q == 0 && (io_bus == CMD_ERASE_CONFIRM || io_bus == CMD_PROG_CONFIRM)) begin
				busy_q <= BUSY_CYC;
				fail_q <= fail_planes;
			end else if (busy_q == 0 && io_bus == CMD_PROG_DUMMY) begin
				busy_q <= LOAD_CYC;
			end
		end
		if (we_rise && ctrl.ale) begin
			addr_q <= addr_q + 1;
			if (addr_q == 3 && (cmd_q == CMD_READ_MAIN || cmd_q == CMD_COPY_READ))
				busy_q <= BUSY_CYC;
		end
	end
endmodule : nand_dev_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
	import nand_host_pkg::*;
	localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
	localparam logic [7:0] PART = 8'h4B; // Arbitrary value
	localparam logic [7:0] RSVD = 8'h5A; // Arbitrary value
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	nand_op_e req_op = OP_STATUS;
	logic [31:0] req_addr = 32'h00000000;
	logic rd_ready = 1'b0;
	logic req_ready, req_error, op_busy, rd_valid, wp_n, io_oe, rb_low;
	nand_status_s status;
	nand_ctrl_s ctrl;
	logic [7:0] rd_data, io_out, dev_data, io_bus;
	logic [3:0] fail = 4'h0;
	logic drain_en = 1'b0;
	logic early = 1'b0;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed = 12249;
	logic [7:0] got_q[$];
	logic [7:0] exp_q[$];
	logic [7:0] exp_cmd[$];

	// Bus resolves to whoever drives it; ready_busy is the inverse of the model's rb_low
	assign io_bus = io_oe ? io_out : dev_data;

	nand_host u_dut (.clock(clock), .resetn(resetn), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_error(req_error),
		.op_busy(op_busy), .status(status), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_data(rd_data), .ctrl(ctrl), .wp_n(wp_n), .io_in(io_bus), .io_out(io_out),
		.io_oe(io_oe), .ready_busy(~rb_low));
	nand_dev_model #(.MAKER_ID(MAKER), .PART_ID(PART), .RSVD_ID(RSVD)) u_dev (.clock(clock),
		.ctrl(ctrl), .io_bus(io_bus), .wp_n(wp_n), .fail_planes(fail), .dev_data(dev_data),
		.rb_low(rb_low));

	initial begin
		forever #10 clock = ~clock;
	end

	// Consumer stalls at random so the buffer sees back-pressure
	always @(posedge clock) begin
		rd_ready <= drain_en && ($random(seed) & 1) != 0;
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
			got_q.push_back(rd_data);
	end

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_idle();
		int n;
		n = 0;
		@(posedge clock);
		while (req_ready !== 1'b1 && n < 5000) begin
			@(posedge clock);
			n++;
		end
	endtask : wait_idle

	// One request; the refusal flag is watched for a few cycles after acceptance
	task automatic issue(input nand_op_e op, input logic [31:0] a, input logic e);
		logic seen;
		seen = 1'b0;
		wait_idle();
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		@(posedge clock);
		req_valid <= 1'b0;
		repeat (3) begin
			#1 seen = seen | req_error;
			@(posedge clock);
		end
		chk(8'(seen), 8'(e));
		wait_idle();
	endtask : issue

	// Command bytes seen by the device against the expected order
	task automatic chk_log();
		chk(8'(u_dev.cmd_log.size()), 8'(exp_cmd.size()));
		foreach (exp_cmd[i])
			chk(u_dev.cmd_log[i], exp_cmd[i]);
		u_dev.cmd_log.delete();
	endtask : chk_log

	// Consumer drains at random, so give it time to collect n bytes
	task automatic wait_got(input int n);
		int w;
		w = 0;
		while (got_q.size() < n && w < 500) begin
			@(posedge clock);
			w++;
		end
	endtask : wait_got

	function automatic logic [31:0] page(input int p);
		return (32'($random(seed)) & 32'hFFFF9FFF) | (32'(p) << 13);
	endfunction : page

	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		repeat (480) begin
			@(posedge clock);
			#1 early = early | req_ready | wp_n;
		end
		chk(8'(early), 8'h00);
		chk(status, STATUS_RESET);
		for (int i = 0; i < 3; i++) begin
			exp_q.push_back(MAKER);
			exp_q.push_back(PART);
			exp_q.push_back(8'hC0);
		end
		issue(OP_READ_ID, 32'h0, 1'b0);
		issue(OP_READ_ID, 32'h0, 1'b0);
		fork
			issue(OP_READ_ID, 32'h0, 1'b0);
			begin
				repeat (300) @(posedge clock);
				#1 chk(8'(op_busy), 8'h01);
				drain_en = 1'b1;
			end
		join
		wait_got(9);
		chk(8'(got_q.size()), 8'h09);
		foreach (exp_q[i])
			chk(got_q[i], exp_q[i]);
		u_dev.cmd_log.delete();
		fail = 4'($random(seed)) | 4'h2;
		for (int p = 0; p < 4; p++)
			issue(OP_ERASE_QUEUE, (32'($random(seed)) & 32'h00FFFF9F) | (32'(p) << 5), 1'b0);
		issue(OP_ERASE_QUEUE, 32'h00000020, 1'b1);
		issue(OP_ERASE_START, 32'h0, 1'b0);
		issue(OP_MP_STATUS, 32'h0, 1'b0);
		chk(status, {3'b110, fail, |fail});
		issue(OP_STATUS, 32'h0, 1'b0);
		chk(status, {3'b110, 4'h0, |fail});
		issue(OP_ERASE_START, 32'h0, 1'b1);
		exp_cmd = '{CMD_ERASE_SETUP, CMD_ERASE_SETUP, CMD_ERASE_SETUP, CMD_ERASE_SETUP,
			CMD_ERASE_CONFIRM, CMD_MP_STATUS, CMD_STATUS};
		chk_log();
		fail = 4'($random(seed)) | 4'h8;
		issue(OP_COPY_SOURCE, page(1), 1'b0);
		issue(OP_COPY_SOURCE, page(3), 1'b0);
		issue(OP_COPY_SOURCE, page(1), 1'b1);
		issue(OP_COPY_DEST, page(2), 1'b1);
		issue(OP_COPY_DEST, page(1), 1'b0);
		issue(OP_COPY_DEST, page(3), 1'b0);
		issue(OP_MP_STATUS, 32'h0, 1'b0);
		chk(status, {3'b110, fail, |fail});
		// Each ready status read hands its raw byte on; copy reads hand on nothing
		wait_got(12);
		chk(8'(got_q.size()), 8'h0C);
		chk(got_q[11], {3'b111, fail, |fail});
		exp_cmd = '{CMD_READ_MAIN, CMD_COPY_READ, CMD_COPY_INPUT, CMD_PROG_DUMMY,
			CMD_COPY_INPUT, CMD_PROG_CONFIRM, CMD_MP_STATUS};
		chk_log();
		issue(OP_RESET, 32'h0, 1'b0);
		chk(status, STATUS_RESET);
		issue(OP_STATUS, 32'h0, 1'b0);
		chk(status, STATUS_RESET);
		exp_cmd = '{CMD_RESET, CMD_STATUS};
		chk_log();
		tally_and_finish();
	end
endmodule : tb
